// ==== hw/sat_pkg.sv ====
package sat_pkg;
	// ------------------------------------------------------------
	// Register map (byte offsets on the plain register port)
	// ------------------------------------------------------------
	localparam logic [3:0] SAT_TX_DATA = 4'h0; // Transmit buffer, bit 8 is ninth bit
	localparam logic [3:0] SAT_RX_DATA = 4'h1; // Receive FIFO head, read pops
	localparam logic [3:0] SAT_TX_CTRL = 4'h2; // Transmit status and control
	localparam logic [3:0] SAT_RX_CTRL = 4'h3; // Receive status and control
	localparam logic [3:0] SAT_BAUD_CTRL = 4'h4; // Baud control
	localparam logic [3:0] SAT_BAUD_DIV = 4'h5; // Divider value, 16 bits
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SAT_TXC_EN = 0; // Transmitter enable
	localparam int SAT_TXC_NINE = 1; // Nine-bit transmit
	localparam int SAT_TXC_BRK = 2; // Send break, self clearing
	localparam int SAT_TXC_SYNC = 3; // Synchronous mode
	localparam int SAT_TXC_HOST = 4; // Synchronous clock host
	localparam int SAT_TXC_EMPTY = 5; // Shift register empty, read only
	localparam int SAT_TXC_BUFE = 6; // Transmit buffer empty, read only
	localparam int SAT_RXC_PORT = 0; // Port enable
	localparam int SAT_RXC_EN = 1; // Receiver enable
	localparam int SAT_RXC_NINE = 2; // Nine-bit receive, not used; SAT_TXC_NINE sets both directions
	localparam int SAT_RXC_ADDR = 3; // Address detect enable
	localparam int SAT_RXC_OVR = 4; // Overrun, write one to clear
	localparam int SAT_RXC_FERR = 5; // Framing error of head entry
	localparam int SAT_RXC_AVAIL = 6; // Receive data available
	localparam int SAT_BDC_WIDE = 0; // Sixteen-bit divider
	localparam int SAT_BDC_POL = 1; // Polarity select
	localparam int SAT_BDC_AUTO = 2; // Auto baud, self clearing
	localparam int SAT_BDC_WAKE = 3; // Wake on break enable
	localparam int SAT_RXD_FERR = 9; // Framing bit beside read data
	// ------------------------------------------------------------
	// Timing constants
	// ------------------------------------------------------------
	localparam logic [15:0] SAT_DIV_RST = 16'h0000;
	localparam logic [3:0] SAT_OVS_LAST = 4'hf; // Sixteen ticks per bit
	localparam logic [3:0] SAT_OVS_MID = 4'h7; // Mid-bit sample tick
	localparam logic [3:0] SAT_BRK_BITS = 4'hd; // Thirteen space bit times
	localparam logic [3:0] SAT_NINE_BITS = 4'h9;
	localparam logic [3:0] SAT_EIGHT_BITS = 4'h8;
	localparam logic [2:0] SAT_AUTO_EDGES = 3'h5; // Falling edges of 0x55 calibration
	// Transmit states, Gray along idle-start-data-stop
	typedef enum logic [1:0] {
		SAT_TX_IDLE = 2'b00,
		SAT_TX_START = 2'b01,
		SAT_TX_DATA_S = 2'b11,
		SAT_TX_STOP = 2'b10
	} sat_tx_e;
	typedef enum logic [1:0] {
		SAT_RX_IDLE = 2'b00,
		SAT_RX_START = 2'b01,
		SAT_RX_DATA_S = 2'b11,
		SAT_RX_STOP = 2'b10
	} sat_rx_e;
endpackage

// ==== hw/sat_rx_fifo.sv ====
// ------------------------------------------------------------
// Two-entry receive FIFO
// ------------------------------------------------------------
module sat_rx_fifo #(
	parameter int WIDTH = 10
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] head,
	output logic full,
	output logic avail
);
	typedef struct packed {
		logic [1:0][WIDTH-1:0] mem; // Entry 0 is head
		logic [1:0] cnt; // Fill level 0..2
	} sat_fifo_s;
	sat_fifo_s fifo_q, fifo_d;

	// Next state: pop shifts entry 1 down, push fills first free slot
	always_comb begin
		logic [1:0] level;
		level = 2'b00;
		fifo_d = fifo_q;
		level = fifo_q.cnt;
		if (pop && level != 2'b00) begin
			fifo_d.mem[0] = fifo_q.mem[1];
			level = level - 2'b01;
		end
		// Caller pushes when full only together with a pop
		if (push && level != 2'b10) begin
			fifo_d.mem[level[0]] = push_data;
			level = level + 2'b01;
		end
		fifo_d.cnt = level;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			fifo_q <= '0;
		end else begin
			fifo_q <= fifo_d;
		end
	end

	assign head = fifo_q.mem[0];
	assign full = fifo_q.cnt == 2'b10;
	assign avail = fifo_q.cnt != 2'b00;
endmodule

// ==== hw/sat_top.sv ====
module sat_top (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic rx_or_sync_data_pin_in,
	output logic rx_or_sync_data_pin_out,
	output logic rx_or_sync_data_pin_oe_n,
	input wire logic tx_or_clock_pin_in,
	output logic tx_or_clock_pin_out,
	output logic tx_or_clock_pin_oe_n,
	output logic configurable_logic_cell_tx,
	output logic wake_event
);
	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] rdata; // Read data, one cycle after strobe
		logic [8:0] tx_buf; // Holding buffer
		logic tx_full; // Holding buffer occupied
		logic [6:0] txc; // Transmit control bits
		logic [3:0] rxc; // Receive control bits
		logic ovr; // Sticky overrun
		logic [3:0] bdc; // Baud control bits
		logic [15:0] div; // Divider reload
		logic [15:0] bcnt; // Baud counter
		logic [3:0] tx_ovs; // Transmit tick within bit
		sat_pkg::sat_tx_e tx_st;
		logic [8:0] transmit_shift_register; // Transmit shift register
		logic [3:0] tx_bits; // Bits left
		logic tx_brk; // Current frame is a break
		logic tx_line; // Line level before polarity
		sat_pkg::sat_rx_e rx_st;
		logic [3:0] rx_ovs;
		logic [8:0] rsr; // Receive shift register
		logic [3:0] rx_bits;
		logic [15:0] acnt; // Auto baud cycle counter
		logic [2:0] aedg; // Auto baud edges seen
		logic rx_prev; // Previous line sample
		logic pin_out; // Registered pin outputs
		logic pin_oe_n;
		logic clk_out;
		logic clk_oe_n;
		logic cell_tx;
		logic wake;
		logic rx_low_run; // Line low at the previous cycle's sample
	} sat_s;
	sat_s s_q, s_d;

	logic [9:0] fifo_head;
	logic fifo_full;
	logic fifo_avail;
	logic fifo_push;
	logic fifo_pop;
	logic [9:0] fifo_wdata;

	// ------------------------------------------------------------
	// Receive buffer
	// ------------------------------------------------------------
	// two character FIFO
	sat_rx_fifo #(
		.WIDTH(10)
	) u_fifo (
		.sys_clk(sys_clk),
		.reset(reset),
		.push(fifo_push),
		.push_data(fifo_wdata),
		.pop(fifo_pop),
		.head(fifo_head),
		.full(fifo_full),
		.avail(fifo_avail)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic tick; // One sixteenth of a bit
		logic port_en;
		logic sync_md;
		logic rx_in;
		logic tx_load;
		logic [3:0] nbits;
		logic [8:0] rword;
		tick = 1'b0;
		port_en = 1'b0;
		sync_md = 1'b0;
		rx_in = 1'b1;
		tx_load = 1'b0;
		nbits = sat_pkg::SAT_EIGHT_BITS;
		rword = '0;
		s_d = s_q;
		fifo_push = 1'b0;
		fifo_pop = 1'b0;
		fifo_wdata = '0;
		s_d.rdata = '0;
		s_d.wake = 1'b0;
		port_en = s_q.rxc[sat_pkg::SAT_RXC_PORT];
		sync_md = s_q.txc[sat_pkg::SAT_TXC_SYNC];
		rx_in = rx_or_sync_data_pin_in;

		// divider eight or sixteen bits wide
		if (s_q.bcnt == 16'h0000) begin
			tick = 1'b1;
			s_d.bcnt = s_q.bdc[sat_pkg::SAT_BDC_WIDE] ? s_q.div : {8'h00, s_q.div[7:0]};
		end else begin
			s_d.bcnt = s_q.bcnt - 16'h0001;
		end

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				sat_pkg::SAT_TX_DATA: begin
					// A write while full is dropped; software polls the empty flag
					if (!s_q.tx_full) begin
						s_d.tx_buf = reg_wdata[8:0];
						s_d.tx_full = 1'b1;
					end
				end
				sat_pkg::SAT_TX_CTRL: begin
					s_d.txc[4:0] = reg_wdata[4:0];
				end
				sat_pkg::SAT_RX_CTRL: begin
					s_d.rxc = reg_wdata[3:0];
					if (reg_wdata[sat_pkg::SAT_RXC_OVR]) begin
						s_d.ovr = 1'b0;
					end
				end
				sat_pkg::SAT_BAUD_CTRL: begin
					s_d.bdc = reg_wdata[3:0];
					s_d.aedg = '0;
					s_d.acnt = '0;
				end
				sat_pkg::SAT_BAUD_DIV: begin
					s_d.div = reg_wdata;
				end
				default: begin
				end
			endcase
		end

		// Register reads, data appear next cycle
		if (reg_rd) begin
			case (reg_addr)
				sat_pkg::SAT_RX_DATA: begin
					s_d.rdata = {6'h00, fifo_head};
					fifo_pop = fifo_avail;
				end
				sat_pkg::SAT_TX_CTRL: begin
					s_d.rdata = {9'h000, s_q.txc};
				end
				sat_pkg::SAT_RX_CTRL: begin
					s_d.rdata = {9'h000, fifo_avail, fifo_head[sat_pkg::SAT_RXD_FERR],
						s_q.ovr, s_q.rxc};
				end
				sat_pkg::SAT_BAUD_CTRL: begin
					s_d.rdata = {12'h000, s_q.bdc};
				end
				sat_pkg::SAT_BAUD_DIV: begin
					s_d.rdata = s_q.div;
				end
				default: begin
					s_d.rdata = '0;
				end
			endcase
		end

		// character length shared by both paths
		// one format, one rate for both directions
		nbits = s_q.txc[sat_pkg::SAT_TXC_NINE] ? sat_pkg::SAT_NINE_BITS
			: sat_pkg::SAT_EIGHT_BITS;

		// ---------------- Transmitter ----------------
		case (s_q.tx_st)
			sat_pkg::SAT_TX_IDLE: begin
				s_d.tx_line = 1'b1;
				// load on the next tick when shift register empty
				// Waiting for a tick keeps the start bit a whole bit period
				if (s_q.txc[sat_pkg::SAT_TXC_EN] && port_en && tick
					&& (s_q.tx_full || s_q.txc[sat_pkg::SAT_TXC_BRK])) begin
					tx_load = 1'b1;
				end
			end
			sat_pkg::SAT_TX_START: begin
				s_d.tx_line = 1'b0;
				if (tick) begin
					s_d.tx_ovs = s_q.tx_ovs + 4'h1;
					// sixteen ticks make one bit period
					if (s_q.tx_ovs == sat_pkg::SAT_OVS_LAST) begin
						s_d.tx_st = sat_pkg::SAT_TX_DATA_S;
						s_d.tx_line = s_q.transmit_shift_register[0];
					end
				end
			end
			sat_pkg::SAT_TX_DATA_S: begin
				if (tick) begin
					s_d.tx_ovs = s_q.tx_ovs + 4'h1;
					if (s_q.tx_ovs == sat_pkg::SAT_OVS_LAST) begin
						s_d.transmit_shift_register = {1'b0, s_q.transmit_shift_register[8:1]};
						s_d.tx_bits = s_q.tx_bits - 4'h1;
						s_d.tx_line = s_q.transmit_shift_register[1];
						// stop bit follows the last data bit
						if (s_q.tx_bits == 4'h1) begin
							s_d.tx_st = sat_pkg::SAT_TX_STOP;
							s_d.tx_line = 1'b1;
						end
					end
				end
			end
			sat_pkg::SAT_TX_STOP: begin
				s_d.tx_line = 1'b1;
				if (tick) begin
					s_d.tx_ovs = s_q.tx_ovs + 4'h1;
					if (s_q.tx_ovs == sat_pkg::SAT_OVS_LAST) begin
						s_d.tx_st = sat_pkg::SAT_TX_IDLE;
						// pending character follows the stop bit
						if (s_q.tx_full && s_q.txc[sat_pkg::SAT_TXC_EN]) begin
							tx_load = 1'b1;
						end
					end
				end
			end
			default: begin
				s_d.tx_st = sat_pkg::SAT_TX_IDLE;
			end
		endcase

		if (tx_load) begin
			s_d.tx_st = sat_pkg::SAT_TX_START;
			s_d.tx_ovs = '0;
			s_d.tx_line = 1'b0;
			// break is start plus twelve space bits
			if (s_q.txc[sat_pkg::SAT_TXC_BRK]) begin
				s_d.transmit_shift_register = '0;
				s_d.tx_bits = sat_pkg::SAT_BRK_BITS - 4'h1;
				s_d.txc[sat_pkg::SAT_TXC_BRK] = 1'b0;
				s_d.tx_brk = 1'b1;
			end else begin
				// nine bits sent as given, no parity added
				s_d.transmit_shift_register = nbits == sat_pkg::SAT_NINE_BITS ? s_q.tx_buf
					: {1'b0, s_q.tx_buf[7:0]};
				s_d.tx_bits = nbits;
				s_d.tx_full = 1'b0;
				s_d.tx_brk = 1'b0;
			end
		end
		// A write landing with the load keeps the new character
		if (reg_wr && reg_addr == sat_pkg::SAT_TX_DATA && tx_load && !s_d.tx_brk) begin
			s_d.tx_buf = reg_wdata[8:0];
			s_d.tx_full = 1'b1;
		end

		s_d.txc[sat_pkg::SAT_TXC_EMPTY] = s_d.tx_st == sat_pkg::SAT_TX_IDLE;
		s_d.txc[sat_pkg::SAT_TXC_BUFE] = s_d.txc[sat_pkg::SAT_TXC_EN] && !s_d.tx_full;

		// ---------------- Receiver ----------------
		// line watched at sixteen ticks per bit
		if (s_q.rxc[sat_pkg::SAT_RXC_EN] && port_en && !sync_md) begin
			case (s_q.rx_st)
				sat_pkg::SAT_RX_IDLE: begin
					if (!rx_in && s_q.rx_prev) begin
						s_d.rx_st = sat_pkg::SAT_RX_START;
						s_d.rx_ovs = '0;
					end
				end
				sat_pkg::SAT_RX_START: begin
					if (tick) begin
						s_d.rx_ovs = s_q.rx_ovs + 4'h1;
						// false start rejected at mid bit
						if (s_q.rx_ovs == sat_pkg::SAT_OVS_MID) begin
							if (rx_in) begin
								s_d.rx_st = sat_pkg::SAT_RX_IDLE;
							end else begin
								s_d.rx_st = sat_pkg::SAT_RX_DATA_S;
								s_d.rx_ovs = '0;
								s_d.rx_bits = nbits;
								s_d.rsr = '0;
							end
						end
					end
				end
				sat_pkg::SAT_RX_DATA_S: begin
					if (tick) begin
						s_d.rx_ovs = s_q.rx_ovs + 4'h1;
						if (s_q.rx_ovs == sat_pkg::SAT_OVS_LAST) begin
							s_d.rsr = {rx_in, s_q.rsr[8:1]};
							s_d.rx_bits = s_q.rx_bits - 4'h1;
							if (s_q.rx_bits == 4'h1) begin
								s_d.rx_st = sat_pkg::SAT_RX_STOP;
							end
						end
					end
				end
				sat_pkg::SAT_RX_STOP: begin
					if (tick) begin
						s_d.rx_ovs = s_q.rx_ovs + 4'h1;
						if (s_q.rx_ovs == sat_pkg::SAT_OVS_LAST) begin
							s_d.rx_st = sat_pkg::SAT_RX_IDLE;
							rword = nbits == sat_pkg::SAT_NINE_BITS ? s_q.rsr
								: {1'b0, s_q.rsr[8:1]};
							// in nine-bit address mode keep only ninth-bit-set words
							if (!(s_q.rxc[sat_pkg::SAT_RXC_ADDR] && nbits
								== sat_pkg::SAT_NINE_BITS && !rword[8])) begin
								// overrun when both entries are taken
								if (fifo_full && !fifo_pop) begin
									s_d.ovr = 1'b1;
								end else begin
									fifo_push = 1'b1;
									// framing error when stop is space
									fifo_wdata = {!rx_in, rword};
								end
							end
						end
					end
				end
				default: begin
					s_d.rx_st = sat_pkg::SAT_RX_IDLE;
				end
			endcase
		end else begin
			s_d.rx_st = sat_pkg::SAT_RX_IDLE;
		end
		s_d.rx_prev = rx_in;

		// auto baud: cycles over eight bits of 0x55, divided by 128
		if (s_q.bdc[sat_pkg::SAT_BDC_AUTO]) begin
			if (s_q.aedg != 3'h0) begin
				s_d.acnt = s_q.acnt + 16'h0001;
			end
			if (!rx_in && s_q.rx_prev) begin
				s_d.aedg = s_q.aedg + 3'h1;
				// The first edge cycle counts, so eight bits give a whole count
				if (s_q.aedg == 3'h0) begin
					s_d.acnt = 16'h0001;
				end
				if (s_q.aedg == sat_pkg::SAT_AUTO_EDGES - 3'h1) begin
					s_d.div = {7'h00, s_q.acnt[15:7]} - 16'h0001;
					s_d.bdc[sat_pkg::SAT_BDC_AUTO] = 1'b0;
					s_d.aedg = '0;
				end
			end
		end

		// break wakes: line low over one whole frame time
		if (!rx_in && s_q.rx_st == sat_pkg::SAT_RX_STOP && tick
			&& s_q.rx_ovs == sat_pkg::SAT_OVS_LAST && s_q.rsr == 9'h000) begin
			s_d.wake = s_q.bdc[sat_pkg::SAT_BDC_WAKE];
		end
		s_d.rx_low_run = !rx_in;

		// transmit stream also feeds logic cell
		s_d.cell_tx = s_d.tx_line ^ s_q.bdc[sat_pkg::SAT_BDC_POL];
		// synchronous host drives clock, client releases it; clock input unused
		// direction set by mode, not software
		if (sync_md) begin
			s_d.pin_out = s_d.tx_line;
			s_d.pin_oe_n = s_d.tx_st == sat_pkg::SAT_TX_IDLE;
			s_d.clk_out = s_d.tx_ovs[3] ^ s_q.bdc[sat_pkg::SAT_BDC_POL];
			s_d.clk_oe_n = !(s_q.txc[sat_pkg::SAT_TXC_HOST] && port_en);
		end else begin
			s_d.pin_out = 1'b1;
			s_d.pin_oe_n = 1'b1;
			s_d.clk_out = s_d.cell_tx;
			s_d.clk_oe_n = !port_en;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_q <= '0;
			s_q.tx_line <= 1'b1;
			s_q.rx_prev <= 1'b1;
			s_q.pin_out <= 1'b1;
			s_q.pin_oe_n <= 1'b1;
			s_q.clk_out <= 1'b1;
			s_q.clk_oe_n <= 1'b1;
			s_q.cell_tx <= 1'b1;
			s_q.div <= sat_pkg::SAT_DIV_RST;
			s_q.txc[sat_pkg::SAT_TXC_EMPTY] <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign rx_or_sync_data_pin_out = s_q.pin_out;
	assign rx_or_sync_data_pin_oe_n = s_q.pin_oe_n;
	assign tx_or_clock_pin_out = s_q.clk_out;
	assign tx_or_clock_pin_oe_n = s_q.clk_oe_n;
	assign configurable_logic_cell_tx = s_q.cell_tx;
	assign wake_event = s_q.wake;
endmodule

// ==== dv/sat_props.sv ====
// ------------------------------------------
// Port-level checker for the transceiver
// ------------------------------------------
module sat_top_props (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic rx_or_sync_data_pin_in,
	input wire logic rx_or_sync_data_pin_out,
	input wire logic rx_or_sync_data_pin_oe_n,
	input wire logic tx_or_clock_pin_in,
	input wire logic tx_or_clock_pin_out,
	input wire logic tx_or_clock_pin_oe_n,
	input wire logic configurable_logic_cell_tx,
	input wire logic wake_event
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Shadow of configuration, seen from bus writes
	logic en_q, sync_q, pol_q, wide_q, wake_q, port_q, brk_q;
	logic [15:0] div_q; // Divider shadow
	logic [15:0] run_q; // Cycles the line has been low
	logic [15:0] hi_q; // Cycles the line has been high, saturating
	logic [3:0] quiet_q; // Cycles since a transmit-side write
	logic [20:0] bit_cyc; // Cycles per bit for the shadowed setting
	logic ok; // Async, port on, plain polarity: pin is the line
	assign bit_cyc = 21'(16 * ((wide_q ? div_q : {8'h00, div_q[7:0]}) + 1));
	assign ok = port_q && !sync_q && !pol_q;
	// Helper state; sync clear keeps it aligned with the design
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			{en_q, sync_q, pol_q, wide_q, wake_q, port_q, brk_q} <= 7'h00;
			div_q <= sat_pkg::SAT_DIV_RST;
			run_q <= 16'h0000;
			hi_q <= 16'h0000;
			quiet_q <= 4'h0;
		end else begin
			if (reg_wr && reg_addr == sat_pkg::SAT_TX_CTRL) begin
				en_q <= reg_wdata[sat_pkg::SAT_TXC_EN];
				sync_q <= reg_wdata[sat_pkg::SAT_TXC_SYNC];
			end
			if (reg_wr && reg_addr == sat_pkg::SAT_RX_CTRL) begin
				port_q <= reg_wdata[sat_pkg::SAT_RXC_PORT];
			end
			if (reg_wr && reg_addr == sat_pkg::SAT_BAUD_CTRL) begin
				wide_q <= reg_wdata[sat_pkg::SAT_BDC_WIDE];
				pol_q <= reg_wdata[sat_pkg::SAT_BDC_POL];
				wake_q <= reg_wdata[sat_pkg::SAT_BDC_WAKE];
			end
			if (reg_wr && reg_addr == sat_pkg::SAT_BAUD_DIV) begin
				div_q <= reg_wdata;
			end
			// Break request lives until the line comes back up
			if (reg_wr && reg_addr == sat_pkg::SAT_TX_CTRL && reg_wdata[sat_pkg::SAT_TXC_BRK]) begin
				brk_q <= 1'b1;
			end else if (run_q != 16'h0000 && tx_or_clock_pin_out) begin
				brk_q <= 1'b0;
			end
			run_q <= tx_or_clock_pin_out ? 16'h0000 : run_q + 16'h0001;
			hi_q <= !tx_or_clock_pin_out ? 16'h0000 : (hi_q == 16'hffff ? hi_q : hi_q + 16'h0001);
			if (reg_wr && (reg_addr == sat_pkg::SAT_TX_DATA || reg_addr == sat_pkg::SAT_TX_CTRL)) begin
				quiet_q <= 4'h0;
			end else if (quiet_q != 4'hf) begin
				quiet_q <= quiet_q + 4'h1;
			end
		end
	end
	property p_reset_mark;
		disable iff (1'b0) reset |=> tx_or_clock_pin_out && configurable_logic_cell_tx
			&& tx_or_clock_pin_oe_n && rx_or_sync_data_pin_oe_n && !wake_event;
	endproperty
	a_reset_mark: assert property (p_reset_mark) else $error("line not at mark after reset");
	property p_low_run;
		ok && $rose(tx_or_clock_pin_out) |-> run_q != 16'h0000 && run_q % bit_cyc == 0;
	endproperty
	a_low_run: assert property (p_low_run) else $error("low run not whole bit times");
	property p_break_len;
		ok && brk_q && $rose(tx_or_clock_pin_out) |-> run_q == bit_cyc * sat_pkg::SAT_BRK_BITS;
	endproperty
	a_break_len: assert property (p_break_len) else $error("break length wrong");
	property p_start_latency;
		reg_wr && reg_addr == sat_pkg::SAT_TX_DATA && en_q && ok && hi_q > 2 * bit_cyc
			&& quiet_q > 4'h4 |=> tx_or_clock_pin_out ##1 tx_or_clock_pin_out ##[1:2] !tx_or_clock_pin_out;
	endproperty
	a_start_latency: assert property (p_start_latency) else $error("start bit late");
	property p_tx_status;
		reg_rd && reg_addr == sat_pkg::SAT_TX_CTRL && en_q && ok && hi_q > 2 * bit_cyc
			&& quiet_q > 4'h4 |=> reg_rdata[6:5] == 2'b11;
	endproperty
	a_tx_status: assert property (p_tx_status) else $error("idle status flags clear");
	property p_cell_copy;
		!pol_q && !sync_q && $stable(pol_q) && $stable(sync_q)
			|-> configurable_logic_cell_tx == tx_or_clock_pin_out;
	endproperty
	a_cell_copy: assert property (p_cell_copy) else $error("logic cell copy differs");
	property p_tx_drive;
		port_q && !sync_q && $past(port_q) |-> !tx_or_clock_pin_oe_n;
	endproperty
	a_tx_drive: assert property (p_tx_drive) else $error("transmit pin not driven");
	property p_data_dir;
		!sync_q && $stable(sync_q) |-> rx_or_sync_data_pin_oe_n;
	endproperty
	a_data_dir: assert property (p_data_dir) else $error("data pin driven in async");
	property p_wake_pulse;
		wake_event |-> wake_q ##1 !wake_event;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse wrong");
endmodule
bind sat_top sat_top_props i_props (.*);

// ==== dv/sat_remote_node.sv ====
// ------------------------------------------
// Remote asynchronous node on the far side
// ------------------------------------------
module sat_remote_node #(
	parameter int BIT_CYC = 32
) (
	input wire logic sys_clk,
	input wire logic line_in,
	output logic line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int rx_bits = 8; // Character length expected from the device
	logic [9:0] rx_q[$]; // Received frames, stop level on top
	initial line_out = 1'b1;
	// Hold one level for whole bit times
	task automatic hold(input logic v, input int bits);
		line_out <= v;
		repeat (bits * BIT_CYC) @(posedge sys_clk);
	endtask
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		@(posedge sys_clk);
		hold(1'b0, 1);
		for (int i = 0; i < n; i++) hold(d[i], 1);
		hold(stop, 1);
		hold(1'b1, 1);
	endtask
	// Long space, used as a break
	task automatic send_low(input int n);
		@(posedge sys_clk);
		hold(1'b0, n);
		hold(1'b1, 2);
	endtask
	// Receiver: mid-bit sampling, frames kept whole
	initial begin : rx_loop
		logic [8:0] d;
		forever begin
			@(negedge line_in);
			repeat (BIT_CYC / 2) @(posedge sys_clk);
			if (line_in === 1'b0) begin
				d = 9'h000;
				for (int i = 0; i < rx_bits; i++) begin
					repeat (BIT_CYC) @(posedge sys_clk);
					d[i] = line_in;
				end
				repeat (BIT_CYC) @(posedge sys_clk);
				rx_q.push_back({line_in, d});
			end
			wait (line_in === 1'b1);
		end
	end
endmodule

// ==== dv/test_serial_async_transceiver.sv ====
module test_serial_async_transceiver;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT = 32; // Cycles per bit at divider 1
	logic sys_clk, reset, reg_wr, reg_rd;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic rx_out, rx_oe_n, rx_pin, tx_pin, tx_oe_n, cell_tx, wake_event, node_line;
	int error_cnt = 0;
	int cmp_count = 0;
	int wake_cnt = 0;
	// receive input and data output mapped to one pin
	// Shared data wire: device wins only while driving
	assign rx_pin = rx_oe_n ? node_line : rx_out;
	sat_top i_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_or_sync_data_pin_in(rx_pin),
		.rx_or_sync_data_pin_out(rx_out), .rx_or_sync_data_pin_oe_n(rx_oe_n),
		.tx_or_clock_pin_in(1'b1), .tx_or_clock_pin_out(tx_pin), .tx_or_clock_pin_oe_n(tx_oe_n),
		.configurable_logic_cell_tx(cell_tx), .wake_event(wake_event));
	sat_remote_node #(.BIT_CYC(BIT)) i_node (.sys_clk(sys_clk), .line_in(tx_pin),
		.line_out(node_line));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Count wake pulses
	always @(posedge sys_clk) if (wake_event === 1'b1) wake_cnt++;
	// ------------------------------------------
	// Bus and check tasks
	// ------------------------------------------
	task automatic final_report;
		if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Gap cycle in front keeps strobes from colliding
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e, string s);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(s, reg_rdata & m, e);
	endtask
	// Bounded wait for frames at the remote node
	task automatic wait_tx(input int n);
		int k;
		k = 0;
		while (i_node.rx_q.size() < n && k < 4000) begin
			@(posedge sys_clk);
			k++;
		end
	endtask
	// Hang guard: whole run needs about 5000 cycles
	initial begin
		repeat (30000) @(posedge sys_clk);
		error_cnt++;
		final_report();
	end
	// ------------------------------------------
	// Main sequence
	// ------------------------------------------
	initial begin : main
		int n, m;
		{reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 4'h0, 16'h0000};
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		rd(4'hf, 16'hffff, 16'h0000, "unmapped read");
		wr(sat_pkg::SAT_BAUD_DIV, 16'h0101);
		wr(sat_pkg::SAT_RX_CTRL, 16'h0003);
		wr(sat_pkg::SAT_TX_CTRL, 16'h0001);
		rd(sat_pkg::SAT_TX_CTRL, 16'h0060, 16'h0060, "idle tx status");
		// Third write finds the buffer full and is dropped
		fork
			i_node.send(9'h05a, 8, 1'b1);
			begin
				wr(sat_pkg::SAT_TX_DATA, 16'h00a5);
				@(posedge sys_clk);
				wr(sat_pkg::SAT_TX_DATA, 16'h003c);
				wr(sat_pkg::SAT_TX_DATA, 16'h000f);
				rd(sat_pkg::SAT_TX_CTRL, 16'h0060, 16'h0000, "busy tx status");
			end
		join
		wait_tx(2);
		repeat (12 * BIT) @(posedge sys_clk);
		chk("tx frame count", 16'(i_node.rx_q.size()), 16'h0002);
		chk("tx frame 0", 16'(i_node.rx_q[0]), 16'h02a5);
		chk("tx frame 1", 16'(i_node.rx_q[1]), 16'h023c);
		rd(sat_pkg::SAT_TX_CTRL, 16'h0060, 16'h0060, "drained tx status");
		rd(sat_pkg::SAT_RX_DATA, 16'hffff, 16'h005a, "duplex rx data");
		rd(sat_pkg::SAT_RX_CTRL, 16'h0040, 16'h0000, "rx empty");
		// Three characters into a two-entry buffer
		for (int i = 1; i < 4; i++) i_node.send(9'(i * 17), 8, 1'b1);
		rd(sat_pkg::SAT_RX_CTRL, 16'h0050, 16'h0050, "overrun flag");
		rd(sat_pkg::SAT_RX_DATA, 16'hffff, 16'h0011, "rx first kept");
		rd(sat_pkg::SAT_RX_DATA, 16'hffff, 16'h0022, "rx second kept");
		wr(sat_pkg::SAT_RX_CTRL, 16'h0013);
		rd(sat_pkg::SAT_RX_CTRL, 16'h0050, 16'h0000, "overrun cleared");
		// Wide divider, same bit time; bad stop level
		wr(sat_pkg::SAT_BAUD_DIV, 16'h0001);
		wr(sat_pkg::SAT_BAUD_CTRL, 16'h0001);
		i_node.send(9'h066, 8, 1'b0);
		rd(sat_pkg::SAT_RX_CTRL, 16'h0060, 16'h0060, "framing head");
		rd(sat_pkg::SAT_RX_DATA, 16'hffff, 16'h0266, "framing data");
		// Nine-bit characters both ways
		wr(sat_pkg::SAT_TX_CTRL, 16'h0003);
		i_node.rx_bits = 9;
		i_node.rx_q.delete();
		fork
			wr(sat_pkg::SAT_TX_DATA, 16'h01a5);
			i_node.send(9'h155, 9, 1'b1);
		join
		wait_tx(1);
		chk("nine-bit tx", 16'(i_node.rx_q[0]), 16'h03a5);
		rd(sat_pkg::SAT_RX_DATA, 16'hffff, 16'h0155, "nine-bit rx");
		// Address detect drops plain data characters
		wr(sat_pkg::SAT_RX_CTRL, 16'h000b);
		i_node.send(9'h033, 9, 1'b1);
		i_node.send(9'h1a0, 9, 1'b1);
		rd(sat_pkg::SAT_RX_DATA, 16'hffff, 16'h01a0, "address char");
		rd(sat_pkg::SAT_RX_CTRL, 16'h0040, 16'h0000, "data char dropped");
		wr(sat_pkg::SAT_TX_CTRL, 16'h0001);
		wr(sat_pkg::SAT_RX_CTRL, 16'h0003);
		i_node.rx_bits = 8;
		// Break transmit: measure the space run
		wr(sat_pkg::SAT_TX_CTRL, 16'h0005);
		n = 0;
		while (tx_pin === 1'b1 && n < 500) begin
			@(posedge sys_clk);
			n++;
		end
		m = 0;
		while (tx_pin === 1'b0 && m < 1000) begin
			@(posedge sys_clk);
			m++;
		end
		chk("break length", 16'(m), 16'(13 * BIT));
		// Incoming break with wake enabled
		wr(sat_pkg::SAT_BAUD_CTRL, 16'h0009);
		i_node.send_low(13);
		chk("wake pulses", 16'(wake_cnt), 16'h0001);
		// Calibration character sets the divider
		wr(sat_pkg::SAT_BAUD_DIV, 16'h00ff);
		wr(sat_pkg::SAT_BAUD_CTRL, 16'h0005);
		i_node.send(9'h055, 8, 1'b1);
		rd(sat_pkg::SAT_BAUD_DIV, 16'hffff, 16'h0001, "measured divider");
		final_report();
	end
endmodule
